// ==== src/uhis_pkg.sv ====
// Operation
// - Software clears any event flag by writing 1; writing 0 leaves it alone.
// - Root hub status or port status change sets the flag at bit 6.
// - Frame number counter overflow sets the flag at bit 5.
// - An unrecoverable system memory bus error sets the fatal flag at bit 4.
// - An isochronous status word not marked not-accessed also sets the fatal flag.
// - A downstream resume request sets the resume flag at bit 3.
// - Each issued start-of-frame token sets the flag at bit 2.
// - Each done-queue head update sets the done-list flag at bit 1.
// - A scheduling overrun sets the overrun flag at bit 0.
// - The ownership-change flag at bit 30 is never set.
// - Every scheduling overrun increments the two-bit counter, even with a pending flag.
// - A flag interrupts only with its enable bit and the master enable set.
package uhis_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_FLAGS = 7;

	// Register byte offsets.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_DISABLE = 8'h08;
	localparam logic [7:0] OFS_OVR_COUNT = 8'h0C;

	// Field positions.
	localparam int BIT_OVERRUN = 0;
	localparam int BIT_DONE_LIST = 1;
	localparam int BIT_FRAME_START = 2;
	localparam int BIT_RESUME = 3;
	localparam int BIT_FATAL = 4;
	localparam int BIT_FRAME_OVF = 5;
	localparam int BIT_ROOT_HUB = 6;
	localparam int BIT_OWNER_CHANGE = 30;
	localparam int BIT_MASTER_EN = 31;
	localparam int OVR_CNT_LSB = 16;
	localparam int OVR_CNT_W = 2;

	// Values after reset.
	localparam logic [6:0] FLAGS_RST = 7'h00;
	localparam logic [6:0] ENABLE_RST = 7'h00;
	localparam logic MASTER_EN_RST = 1'h0;
	localparam logic [1:0] OVR_CNT_RST = 2'h0;
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

// ==== src/uhis_flag.sv ====
`timescale 1ns/10ps
`default_nettype none
// One sticky event flag; a set in the same cycle as a clear wins.
module uhis_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic set_pulse,
	input wire logic clr_pulse,
	output logic flag_q
);
	import uhis_pkg::*;

	logic flag_d;

	assign flag_d = set_pulse | (flag_q & ~clr_pulse);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'h0;
		end else if (pclk_en) begin
			flag_q <= flag_d;
		end
	end
endmodule
`default_nettype wire

// ==== src/uhis_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module uhis_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uhis_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic evt_root_hub_change,
	input wire logic evt_frame_overflow,
	input wire logic evt_bus_error,
	input wire logic evt_iso_cc_bad,
	input wire logic evt_resume,
	input wire logic evt_frame_start,
	input wire logic evt_done_head,
	input wire logic evt_overrun,
	output logic irq
);
	import uhis_pkg::*;

	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic irq_q;
	logic irq_d;
	logic [NUM_FLAGS-1:0] flags_q;
	logic [NUM_FLAGS-1:0] enable_q;
	logic [NUM_FLAGS-1:0] enable_d;
	logic master_en_q;
	logic master_en_d;
	logic [OVR_CNT_W-1:0] ovr_cnt_q;
	logic [OVR_CNT_W-1:0] ovr_cnt_d;

	// Request decode. The slave answers in the second access cycle, so every
	// transfer takes one setup and two access cycles.
	wire req_w = psel & penable & ~pready_q;
	wire done_w = psel & penable & pready_q;
	wire wr_done_w = done_w & pwrite;
	wire hit_status_w = (paddr == OFS_STATUS);
	wire hit_enable_w = (paddr == OFS_ENABLE);
	wire hit_disable_w = (paddr == OFS_DISABLE);
	wire hit_count_w = (paddr == OFS_OVR_COUNT);
	wire mapped_w = hit_status_w | hit_enable_w | hit_disable_w | hit_count_w;
	wire wr_status_w = wr_done_w & hit_status_w;
	wire wr_enable_w = wr_done_w & hit_enable_w;
	wire wr_disable_w = wr_done_w & hit_disable_w;

	// Event sources by flag position; the fatal flag takes two, bus error and bad isochronous status.
	wire [NUM_FLAGS-1:0] set_vec_w = {
		evt_root_hub_change,
		evt_frame_overflow,
		evt_bus_error | evt_iso_cc_bad,
		evt_resume,
		evt_frame_start,
		evt_done_head,
		evt_overrun
	};
	// Only bits 6..0 reach the flags; bit 31 and the reserved bits are dropped.
	wire [NUM_FLAGS-1:0] clr_vec_w = wr_status_w ? pwdata[NUM_FLAGS-1:0] :
		{NUM_FLAGS{1'h0}};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
			uhis_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.pclk_en(pclk_en),
				.set_pulse(set_vec_w[gi]),
				.clr_pulse(clr_vec_w[gi]),
				.flag_q(flags_q[gi])
			);
		end
	endgenerate

	// Enable register is write-1-to-set; the disable offset clears its bits.
	assign enable_d = wr_enable_w ? (enable_q | pwdata[NUM_FLAGS-1:0]) :
		wr_disable_w ? (enable_q & ~pwdata[NUM_FLAGS-1:0]) : enable_q;
	assign master_en_d = wr_enable_w ? (master_en_q | pwdata[BIT_MASTER_EN]) :
		wr_disable_w ? (master_en_q & ~pwdata[BIT_MASTER_EN]) : master_en_q;

	// The counter wraps silently; software samples it to see lost overruns.
	assign ovr_cnt_d = evt_overrun ? ovr_cnt_q + 2'h1 : ovr_cnt_q;

	// Owner-change position is hard zero: no management interrupt exists.
	wire [31:0] status_rd_w = {1'h0, 1'h0, 23'h00_0000, flags_q};
	wire [31:0] enable_rd_w = {master_en_q, 1'h0, 23'h00_0000, enable_q};
	wire [31:0] count_rd_w = {14'h0000, ovr_cnt_q, 16'h0000};
	assign prdata_d = !pwrite && hit_status_w ? status_rd_w :
		!pwrite && hit_enable_w ? enable_rd_w :
		!pwrite && hit_count_w ? count_rd_w : 32'h0000_0000;
	assign pready_d = req_w;

	// The interrupt line is one cycle behind the flags it reflects.
	assign irq_d = master_en_q & (|(flags_q & enable_q));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
			prdata_q <= PRDATA_RST;
		end else if (pclk_en) begin
			pready_q <= pready_d;
			pslverr_q <= req_w & ~mapped_w;
			prdata_q <= req_w ? prdata_d : PRDATA_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= ENABLE_RST;
			master_en_q <= MASTER_EN_RST;
			ovr_cnt_q <= OVR_CNT_RST;
			irq_q <= 1'h0;
		end else if (pclk_en) begin
			enable_q <= enable_d;
			master_en_q <= master_en_d;
			ovr_cnt_q <= ovr_cnt_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// Helper terms read only by the checks below.
	wire [NUM_FLAGS-1:0] clr_only_w = clr_vec_w & ~set_vec_w;
	wire [NUM_FLAGS-1:0] kept_w = flags_q & ~clr_vec_w;
	wire rd_req_w = pclk_en & req_w & ~pwrite;
	wire [NUM_FLAGS-1:0] pw_flags_w = pwdata[NUM_FLAGS-1:0];

	property p_w1c_clear;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && wr_status_w) |=> ((flags_q & $past(clr_only_w)) == 7'h00);
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("Flag survived a clear.");

	property p_write_zero_keeps;
		@(posedge pclk) disable iff (!presetn)
		pclk_en |=> (($past(kept_w) & ~flags_q) == 7'h00);
	endproperty
	a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("Flag lost.");

	property p_root_hub;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_root_hub_change) |=> flags_q[BIT_ROOT_HUB];
	endproperty
	a_root_hub: assert property (p_root_hub) else $error("Root hub flag not set.");

	property p_frame_ovf;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_frame_overflow) |=> flags_q[BIT_FRAME_OVF];
	endproperty
	a_frame_ovf: assert property (p_frame_ovf) else $error("Overflow flag not set.");

	property p_bus_error;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_bus_error) |=> flags_q[BIT_FATAL];
	endproperty
	a_bus_error: assert property (p_bus_error) else $error("Fatal flag missed.");

	property p_iso_cc;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_iso_cc_bad) |=> flags_q[BIT_FATAL];
	endproperty
	a_iso_cc: assert property (p_iso_cc) else $error("Fatal flag missed.");

	property p_resume;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_resume) |=> flags_q[BIT_RESUME];
	endproperty
	a_resume: assert property (p_resume) else $error("Resume flag not set.");

	property p_frame_start;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_frame_start) |=> flags_q[BIT_FRAME_START];
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("Frame start not set.");

	property p_done_head;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_done_head) |=> flags_q[BIT_DONE_LIST];
	endproperty
	a_done_head: assert property (p_done_head) else $error("Done list flag not set.");

	property p_overrun;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_overrun) |=> flags_q[BIT_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun) else $error("Overrun flag not set.");

	property p_owner_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready_q && $past(hit_status_w)) |-> !prdata_q[BIT_OWNER_CHANGE];
	endproperty
	a_owner_zero: assert property (p_owner_zero) else $error("Owner change bit set.");

	property p_ovr_count;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && evt_overrun) |=> (ovr_cnt_q == 2'($past(ovr_cnt_q) + 2'h1));
	endproperty
	a_ovr_count: assert property (p_ovr_count) else $error("Counter did not step.");

	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn)
		pclk_en |=> (irq == ($past(master_en_q) && (|($past(flags_q) & $past(enable_q)))));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("Interrupt gating wrong.");

	property p_answer_time;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && req_w) |=> pready;
	endproperty
	a_answer_time: assert property (p_answer_time) else $error("Slave did not answer in time.");

	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
		pclk_en |=> ((flags_q & $past(set_vec_w)) == $past(set_vec_w));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Event lost to a clear.");

	property p_no_spurious;
		@(posedge pclk) disable iff (!presetn)
		pclk_en |=> ((flags_q & ~$past(flags_q) & ~$past(set_vec_w)) == 7'h00);
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("Flag rose unasked.");

	// Read data is judged at the edge that ends the second access cycle, where pready stands.
	property p_status_data;
		@(posedge pclk) disable iff (!presetn)
		$past(rd_req_w && hit_status_w) |-> (prdata_q[NUM_FLAGS-1:0] == $past(flags_q));
	endproperty
	a_status_data: assert property (p_status_data) else $error("Status data wrong.");

	property p_status_resv;
		@(posedge pclk) disable iff (!presetn)
		$past(rd_req_w && hit_status_w) |-> (prdata_q[31:NUM_FLAGS] == 25'h000_0000);
	endproperty
	a_status_resv: assert property (p_status_resv) else $error("Reserved bit set.");

	property p_owner_never;
		@(posedge pclk) disable iff (!presetn)
		!prdata_q[BIT_OWNER_CHANGE];
	endproperty
	a_owner_never: assert property (p_owner_never) else $error("Owner change bit set.");

	property p_enable_data;
		@(posedge pclk) disable iff (!presetn)
		$past(rd_req_w && hit_enable_w) |->
			(prdata_q == {$past(master_en_q), 1'h0, 23'h00_0000, $past(enable_q)});
	endproperty
	a_enable_data: assert property (p_enable_data) else $error("Enable data wrong.");

	property p_disable_data;
		@(posedge pclk) disable iff (!presetn)
		$past(rd_req_w && hit_disable_w) |-> (prdata_q == 32'h0000_0000);
	endproperty
	a_disable_data: assert property (p_disable_data) else $error("Disable data set.");

	property p_count_data;
		@(posedge pclk) disable iff (!presetn)
		$past(rd_req_w && hit_count_w) |-> (prdata_q[OVR_CNT_LSB +: OVR_CNT_W] == $past(ovr_cnt_q));
	endproperty
	a_count_data: assert property (p_count_data) else $error("Count data wrong.");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		$past(pclk_en && req_w && !mapped_w) |-> (pslverr && (prdata_q == 32'h0000_0000));
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");

	property p_enable_set;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && wr_enable_w) |=> ((enable_q & $past(pw_flags_w)) == $past(pw_flags_w));
	endproperty
	a_enable_set: assert property (p_enable_set) else $error("Enable not set.");

	property p_disable_clr;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && wr_disable_w) |=> ((enable_q & $past(pw_flags_w)) == 7'h00);
	endproperty
	a_disable_clr: assert property (p_disable_clr) else $error("Enable not cleared.");

	property p_master_set;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && wr_enable_w && pwdata[BIT_MASTER_EN]) |=> master_en_q;
	endproperty
	a_master_set: assert property (p_master_set) else $error("Master not set.");

	property p_master_clr;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && wr_disable_w && pwdata[BIT_MASTER_EN]) |=> !master_en_q;
	endproperty
	a_master_clr: assert property (p_master_clr) else $error("Master not cleared.");

	property p_enable_hold;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && !wr_enable_w && !wr_disable_w) |=> ($stable(enable_q) && $stable(master_en_q));
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("Enable moved.");

	property p_count_hold;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && !evt_overrun) |=> $stable(ovr_cnt_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("Counter moved.");

	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		(pclk_en && pready) |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("Ready stood too long.");

	property p_idle_quiet;
		@(posedge pclk) disable iff (!presetn)
		!pready |-> ((prdata == 32'h0000_0000) && !pslverr);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("Bus outputs not idle.");

	property p_ready_cause;
		@(posedge pclk) disable iff (!presetn)
		(pready && $past(pclk_en)) |-> $past(req_w);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("Ready without a request.");

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!pclk_en |=> ($stable(flags_q) && $stable(ovr_cnt_q) && $stable(irq) && $stable(pready));
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while frozen.");

	c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	c_set_beats_clear: cover property (@(posedge pclk) disable iff (!presetn)
		pclk_en && wr_status_w && |(clr_vec_w & set_vec_w));
	c_count_wrap: cover property (@(posedge pclk) disable iff (!presetn)
		pclk_en && evt_overrun && ovr_cnt_q == 2'h3);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
	c_freeze: cover property (@(posedge pclk) disable iff (!presetn) !pclk_en && evt_resume);
endmodule
`default_nettype wire

// ==== verification/uhis_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module uhis_top_test;
	import uhis_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pclk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] evt = 8'h00;
	logic irq;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int checked = 0;
	uhis_top dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.evt_root_hub_change(evt[6]), .evt_frame_overflow(evt[5]), .evt_bus_error(evt[4]),
		.evt_iso_cc_bad(evt[7]), .evt_resume(evt[3]), .evt_frame_start(evt[2]),
		.evt_done_head(evt[1]), .evt_overrun(evt[0]), .irq(irq));
	initial begin
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge pclk);
		evt <= m;
		@(posedge pclk);
		evt <= 8'h00;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic test_reset;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h0, rd);
		apb(1'b0, OFS_ENABLE, 32'h0);
		chk("enable", 32'h0, rd);
		apb(1'b0, OFS_OVR_COUNT, 32'h0);
		chk("count", 32'h0, rd);
		chk("irq", 32'h0, {31'h0, irq});
	endtask
	// Two sources share the fatal flag, so source 7 maps back onto bit 4.
	task automatic test_sticky;
		logic [31:0] b;
		for (int i = 0; i < 8; i++) begin
			b = 32'h1 << ((i == 7) ? 4 : i);
			pulse(8'h01 << i);
			settle(3);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("flag set", b, rd);
			apb(1'b1, OFS_STATUS, ~b);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("flag after w0", b, rd);
			apb(1'b1, OFS_STATUS, b);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("flag after w1", 32'h0, rd);
		end
	endtask
	task automatic test_count;
		for (int i = 0; i < 5; i++)
			pulse(8'h01);
		settle(2);
		apb(1'b1, OFS_OVR_COUNT, 32'hFFFF_FFFF);
		apb(1'b0, OFS_OVR_COUNT, 32'h0);
		// One overrun from the sticky test plus five here: six events wrap to two.
		chk("count wraps", 32'h0002_0000, rd);
		apb(1'b1, OFS_STATUS, 32'h0000_0001);
	endtask
	task automatic test_irq;
		pulse(8'h04);
		apb(1'b1, OFS_ENABLE, 32'h0000_0004);
		settle(2);
		chk("irq no master", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_ENABLE, 32'h8000_0000);
		settle(2);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(1'b0, OFS_ENABLE, 32'h0);
		chk("enable rb", 32'h8000_0004, rd);
		apb(1'b1, OFS_STATUS, 32'h0000_0004);
		settle(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		pulse(8'h04);
		settle(2);
		chk("irq again", 32'h1, {31'h0, irq});
		apb(1'b1, OFS_DISABLE, 32'h8000_0000);
		settle(2);
		chk("irq master off", 32'h0, {31'h0, irq});
		apb(1'b0, OFS_DISABLE, 32'h0);
		chk("disable rb", 32'h0, rd);
		apb(1'b1, OFS_DISABLE, 32'h0000_0004);
		apb(1'b0, OFS_ENABLE, 32'h0);
		chk("enable off", 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
	endtask
	// A resume event while the clock enable is low must not reach its flag.
	task automatic test_freeze;
		@(posedge pclk);
		pclk_en <= 1'b0;
		pulse(8'h08);
		@(posedge pclk);
		pclk_en <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("frozen", 32'h0000_0004, rd);
	endtask
	initial begin
		#(40 * 5000);
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_sticky();
		test_count();
		test_irq();
		test_freeze();
		give_verdict();
	end
endmodule
`default_nettype wire
